// [idf_filter_top.v]
// Multi-channel input debounce filter with a classic Wishbone register slave
//
// Summary of operation
// - Glitch-detect mode passes an accepted input edge to the output at once.
// - After that edge, glitch-detect holds output until input is steady a full debounce time.
// - Glitch-detect accepts an edge only after the input was steady for the debounce time.
// - Once steady that long, the next edge appears on the output without delay.
// - While disturbances prevent stability, glitch-detect output keeps its current level.
// - A software bypass routes the input around both modes, passing every glitch.
// - Classic mode rejects short glitches, passing transitions only after stability.
// - A glitch burst shorter than the debounce time gives no classic output transition; glitch-detect passes only its first edge.
// - Each channel offers sixteen debounce times from 500 ns to 25.5 ms.
// - An optional inverter before the filter selects rising or falling edge sensitivity.
// - Classic output changes only after an edge then the new level held the debounce time.
// - In bypass the time setting is ignored; the inverter output feeds the output register every cycle.
//
// Chosen here: the Wishbone interface to the registers and the address map.
`timescale 1ns/1ps
`include "idf_map.vh"

module idf_filter_top #(
   parameter NCH        = 4,
   parameter CNT_W      = 16,
   parameter PRE_W      = 8,
   parameter TICK_CYC   = `IDF_TICK_CYC,
   parameter LONG_TICKS = `IDF_LONG_TICKS
) (
   input  wire                      clk_sys,
   input  wire                      nrst,
   input  wire [`IDF_ADR_W-1:0]     wb_adr_i,
   input  wire [31:0]               wb_dat_i,
   input  wire [3:0]                wb_sel_i,
   input  wire                      wb_we_i,
   input  wire                      wb_cyc_i,
   input  wire                      wb_stb_i,
   output reg  [31:0]               wb_dat_o,
   output reg                       wb_ack_o,
   input  wire [NCH-1:0]            sig_in,
   output wire [NCH-1:0]            flt_out
);

   // Parameters are narrowed on purpose through sized copies
   localparam [31:0]       LONG_W32   = LONG_TICKS;
   localparam [31:0]       PRE_W32    = TICK_CYC - 1;
   localparam [CNT_W-1:0]  LONG_T     = LONG_W32[CNT_W-1:0];
   localparam [PRE_W-1:0]  PRE_LAST   = PRE_W32[PRE_W-1:0];

   // ==========================================
   // Debounce interval table, in ticks of 500 ns
   // Steps 0..14 double from one tick; the last step is the longest interval.
   function [CNT_W-1:0] tsel_ticks;
      input [3:0] tsel;
      begin
         if (tsel == `IDF_TSEL_LONG) begin
            tsel_ticks = LONG_T;
         end else begin
            tsel_ticks = {{(CNT_W-1){1'b0}}, 1'b1} << tsel;
         end
      end
   endfunction

   // ==========================================
   // Wishbone slave
   wire                     bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire                     bus_wr  = bus_req & wb_we_i & wb_sel_i[0];
   reg  [`IDF_CTRL_W-1:0]   ctrl_ff [0:NCH-1];
   wire [NCH-1:0]           stbl_w;
   wire [NCH-1:0]           raw_w;
   reg  [31:0]              nxt_rdata;
   integer                  k;
   integer                  j;

   always @* begin
      nxt_rdata = 32'h0000_0000;
      if (wb_adr_i == `IDF_OFS_STAT_OUT) begin
         nxt_rdata[NCH-1:0] = flt_out;
      end else if (wb_adr_i == `IDF_OFS_STAT_STBL) begin
         nxt_rdata[NCH-1:0] = stbl_w;
      end else if (wb_adr_i == `IDF_OFS_STAT_RAW) begin
         nxt_rdata[NCH-1:0] = raw_w;
      end else begin
         for (k = 0; k < NCH; k = k + 1) begin
            if (wb_adr_i == `IDF_OFS_CTRL0 + 4 * k) begin
               nxt_rdata[`IDF_CTRL_W-1:0] = ctrl_ff[k];
            end
         end
      end
   end

   // Unmapped addresses are acknowledged, read as zero and ignore writes
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req) begin
            wb_dat_o <= nxt_rdata;
         end
      end
   end

   // All control words live in one process so the array has a single driver
   always @(posedge clk_sys or negedge nrst) begin
      if (!nrst) begin
         for (j = 0; j < NCH; j = j + 1) begin
            ctrl_ff[j] <= `IDF_CTRL_RST;
         end
      end else begin
         for (j = 0; j < NCH; j = j + 1) begin
            if (bus_wr && wb_adr_i == `IDF_OFS_CTRL0 + 4 * j) begin
               ctrl_ff[j] <= wb_dat_i[`IDF_CTRL_W-1:0];
            end
         end
      end
   end

   // ==========================================
   // Per-channel filters
   genvar i;
   generate
      for (i = 0; i < NCH; i = i + 1) begin : g_ch
         reg  [PRE_W-1:0] pre_ff;
         reg  [CNT_W-1:0] cnt_ff;
         reg              prev_ff;
         reg              out_ff;
         wire [1:0]       mode   = ctrl_ff[i][`IDF_F_MODE_MSB:`IDF_F_MODE_LSB];
         wire             in_s   = sig_in[i] ^ ctrl_ff[i][`IDF_F_INV];
         wire             chg    = in_s ^ prev_ff;
         wire             stable = cnt_ff >= tsel_ticks(ctrl_ff[i][`IDF_F_TSEL_MSB:`IDF_F_TSEL_LSB]);

         assign stbl_w[i]  = stable;
         assign raw_w[i]   = in_s;
         assign flt_out[i] = out_ff;

         // Stability timer: every sampled change restarts it, and it parks once
         // the selected interval is reached so it cannot wrap.
         always @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               prev_ff <= 1'b0;
               pre_ff  <= {PRE_W{1'b0}};
               cnt_ff  <= {CNT_W{1'b0}};
            end else begin
               prev_ff <= in_s;
               if (chg) begin
                  pre_ff <= {PRE_W{1'b0}};
                  cnt_ff <= {CNT_W{1'b0}};
               end else if (!stable) begin
                  if (pre_ff == PRE_LAST) begin
                     pre_ff <= {PRE_W{1'b0}};
                     cnt_ff <= cnt_ff + 1'b1;
                  end else begin
                     pre_ff <= pre_ff + 1'b1;
                  end
               end
            end
         end

         always @(posedge clk_sys or negedge nrst) begin
            if (!nrst) begin
               out_ff <= `IDF_OUT_RST;
            end else begin
               case (mode)
                  `IDF_MODE_AFTER: begin
                     // Follows only a level that has already held the full interval
                     if (stable) begin
                        out_ff <= prev_ff;
                     end
                  end
                  `IDF_MODE_BEFORE: begin
                     // Stable before the edge: the edge passes now and restarts the
                     // timer, so later edges of the burst are locked out. While
                     // stable and unchanged it realigns with the settled level.
                     if (stable) begin
                        out_ff <= in_s;
                     end
                  end
                  default: begin
                     // Time setting ignored; inverter output passes every cycle
                     out_ff <= in_s;
                  end
               endcase
            end
         end
      end
   endgenerate

endmodule // idf_filter_top

// [idf_map.vh]
// Constants for the input debounce filter: register map, fields, resets and timing
`ifndef IDF_MAP_VH
`define IDF_MAP_VH

// ==========================================
// Register offsets (byte addresses)
`define IDF_OFS_CTRL0      8'h00
`define IDF_OFS_STAT_OUT   8'h20
`define IDF_OFS_STAT_STBL  8'h24
`define IDF_OFS_STAT_RAW   8'h28
`define IDF_ADR_W          8

// ==========================================
// Channel control register fields
`define IDF_F_TSEL_LSB     0
`define IDF_F_TSEL_MSB     3
`define IDF_F_MODE_LSB     4
`define IDF_F_MODE_MSB     5
`define IDF_F_INV          6
`define IDF_CTRL_W         7

// ==========================================
// Debounce mode codes
`define IDF_MODE_AFTER     2'h0
`define IDF_MODE_BEFORE    2'h1
`define IDF_MODE_BYPASS    2'h2

// ==========================================
// Reset values
`define IDF_CTRL_RST       7'h20
`define IDF_OUT_RST        1'h0

// ==========================================
// Timing
`define IDF_CLK_MHZ        50
`define IDF_TICK_NS        500
`define IDF_LONG_US        25500
`define IDF_TICK_CYC       ((`IDF_TICK_NS * `IDF_CLK_MHZ) / 1000)
`define IDF_LONG_TICKS     ((`IDF_LONG_US * 1000) / `IDF_TICK_NS)
`define IDF_TSEL_LONG      4'hF

`endif

// [idf_checker.sv]
// Port checker for the debounce filter top
`timescale 1ns/1ps
module idf_chk #(parameter NCH = 4) (
   input wire           clk_sys,
   input wire           nrst,
   input wire [7:0]     wb_adr_i,
   input wire [31:0]    wb_dat_i,
   input wire [3:0]     wb_sel_i,
   input wire           wb_we_i,
   input wire           wb_cyc_i,
   input wire           wb_stb_i,
   input wire [31:0]    wb_dat_o,
   input wire           wb_ack_o,
   input wire [NCH-1:0] sig_in,
   input wire [NCH-1:0] flt_out
);
   reg  [6:0] c_ff;
   wire [1:0] md  = c_ff[5:4];
   wire       in0 = sig_in[0] ^ c_ff[6];
   wire       rd  = wb_ack_o && !wb_we_i;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   // Shadow of channel 0 control, so mode checks need no hierarchy probing
   always @(posedge clk_sys or negedge nrst)
      if (!nrst) c_ff <= 7'h20;
      else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 8'h00)
         c_ff <= wb_dat_i[6:0];
   a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack late");
   a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack long");
   a_hole_zero: assert property (rd && wb_adr_i == 8'h40 |-> wb_dat_o == 32'h0)
      else $error("hole read");
   a_ctrl_read: assert property (rd && wb_adr_i == 8'h00 |-> wb_dat_o == {25'h0, c_ff})
      else $error("ctrl read");
   a_bypass_pass: assert property (md[1] && $stable(c_ff) |=> flt_out[0] == $past(in0))
      else $error("bypass");
   a_after_stable: assert property (md == 2'h0 && $stable(c_ff) && !$stable(flt_out[0])
      |-> flt_out[0] == $past(in0) && $past(in0) == $past(in0, 2)) else $error("after");
   a_before_hold: assert property (md == 2'h1 && !$stable(flt_out[0])
      |=> ($stable(flt_out[0]) || md != 2'h1) [*2]) else $error("lockout");
   a_before_edge: assert property (md == 2'h1 && $stable(c_ff) && !$stable(flt_out[0])
      |-> flt_out[0] == $past(in0)) else $error("before");
   c_after: cover property (md == 2'h0 && !$stable(flt_out[0]));
   c_before: cover property (md == 2'h1 && !$stable(flt_out[0]));
   c_bypass: cover property (md[1] && !$stable(flt_out[0]));
endmodule // idf_chk
bind idf_filter_top idf_chk #(.NCH(NCH)) u_chk (.*);

// [idf_src.sv]
// Model of a bouncing switch feeding channel 0
`timescale 1ns/1ps
module idf_src (
   input wire clk_sys,
   input wire lvl,
   input wire bnc,
   output reg sig
);
   initial sig = 1'b0;
   // Worst-case contact: flips every cycle while bouncing
   always @(posedge clk_sys) sig <= bnc ? ~sig : lvl;
endmodule // idf_src

// [test_input_debounce_filter.sv]
// Bench for the debounce filter
`timescale 1ns/1ps
module test_input_debounce_filter;
   reg clk_sys = 1'b0, nrst = 1'b0, we = 1'b0, cyc = 1'b0, stb = 1'b0, lvl = 1'b0, bnc = 1'b0;
   reg [7:0] adr = 8'h0;
   reg [31:0] dat = 32'h0;
   reg [3:0] sel = 4'hF;
   reg [2:0] hi = 3'h0;
   wire s0, ack;
   wire [31:0] rdat;
   wire [3:0] flt;
   integer error_cnt = 0, n_checks = 0, i;
   idf_filter_top #(.TICK_CYC(2), .LONG_TICKS(40)) i_dut (.clk_sys(clk_sys), .nrst(nrst), .wb_adr_i(adr),
      .wb_dat_i(dat), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_dat_o(rdat),
      .wb_ack_o(ack), .sig_in({hi, s0}), .flt_out(flt));
   idf_src i_src (.clk_sys(clk_sys), .lvl(lvl), .bnc(bnc), .sig(s0));
   initial forever #10 clk_sys = ~clk_sys;
   task stop_test;
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task chk(input [31:0] s, input [31:0] e);
      n_checks = n_checks + 1;
      if (s !== e) begin
         error_cnt = error_cnt + 1;
         $display("unexpected at %0t: saw %h wanted %h", $time, s, e);
      end
   endtask
   task bus(input [7:0] a, input [31:0] d, input w, input [3:0] s, input [31:0] e);
      integer k;
      @(posedge clk_sys);
      {adr, dat, we, sel, cyc, stb} <= {a, d, w, s, 2'h3};
      k = 0;
      do begin
         @(posedge clk_sys);
         k = k + 1;
      end while (ack !== 1'b1 && k < 20);
      {cyc, stb} <= 2'h0;
      if (!w || k >= 20) chk(k < 20 ? rdat : 32'hFFFF, e);
      if (k >= 20) stop_test;
   endtask
   // Edges counted from the cycle the source is told to move
   task meas(input v, input f, input integer e);
      integer n;
      @(posedge clk_sys);
      lvl <= v;
      n = 0;
      do begin
         @(posedge clk_sys);
         #1 n = n + 1;
      end while (flt[0] !== f && n < 400);
      chk(n, e);
      if (n >= 400) stop_test;
   endtask
   task burst;
      @(posedge clk_sys);
      bnc <= 1'b1;
      repeat (5) @(posedge clk_sys);
      bnc <= 1'b0;
      repeat (12) @(posedge clk_sys);
   endtask
   initial begin
      repeat (10) @(posedge clk_sys);
      nrst <= 1'b1;
      bus(8'h00, 0, 0, 4'hF, 32'h20);
      bus(8'h40, 32'h7F, 1, 4'hF, 0);
      bus(8'h40, 0, 0, 4'hF, 0);
      hi <= 3'h5;
      meas(1, 1, 2);
      burst;
      bus(8'h00, 32'h6F, 1, 4'hF, 0);
      meas(0, 1, 2);
      bus(8'h20, 0, 0, 4'hF, 32'hB);
      bus(8'h28, 0, 0, 4'hF, 32'hB);
      bus(8'h00, 32'h12, 1, 4'h0, 0);
      bus(8'h00, 0, 0, 4'hF, 32'h6F);
      for (i = 0; i < 16; i = i + (i < 3 ? 1 : 12)) begin
         bus(8'h00, i, 1, 4'hF, 0);
         repeat (100) @(posedge clk_sys);
         meas(1, 1, 3 + 2 * (i == 15 ? 40 : 1 << i));
         meas(0, 0, 3 + 2 * (i == 15 ? 40 : 1 << i));
      end
      bus(8'h00, 32'h02, 1, 4'hF, 0);
      burst;
      chk(flt[0], 0);
      bus(8'h00, 32'h12, 1, 4'hF, 0);
      repeat (20) @(posedge clk_sys);
      meas(1, 1, 2);
      burst;
      chk(flt[0], 1);
      meas(0, 0, 2);
      stop_test;
   end
endmodule // test_input_debounce_filter
